// ===== rtl/motor_cfg_pkg.sv
package motor_cfg_pkg;

    // ----------------------------------------
    // Register map (printed offsets are indices)
    // ----------------------------------------
    localparam logic [7:0] SPIN_STOP_IDX   = 8'h09;
    localparam logic [7:0] SPEED_STALL_IDX = 8'h0A;
    localparam logic [7:0] PHASE_LEAD_IDX  = 8'h0B;
    localparam logic [7:0] SKEW_IDX        = 8'h0C;
    localparam logic [7:0] IRQ_STATUS_IDX  = 8'h10;
    localparam logic [7:0] IRQ_MASK_IDX    = 8'h11;
    localparam logic [7:0] STATE_IDX       = 8'h12;
    localparam logic [7:0] FAULT_CLR_IDX   = 8'h13;

    localparam logic [7:0] SPIN_STOP_RST   = 8'h01;
    localparam logic [7:0] SPEED_STALL_RST = 8'h41;
    localparam logic [7:0] PHASE_LEAD_RST  = 8'h00;
    localparam logic [7:0] SKEW_RST        = 8'h00;

    // Writable bit masks; reserved bits read zero
    localparam logic [7:0] SPIN_STOP_WMASK   = 8'h1F;
    localparam logic [7:0] SPEED_STALL_WMASK = 8'hDF;
    localparam logic [7:0] PHASE_LEAD_WMASK  = 8'h07;
    localparam logic [7:0] SKEW_WMASK        = 8'h1F;

    // ----------------------------------------
    // Timing at 10 MHz
    // ----------------------------------------
    localparam int CLK_HZ        = 10_000_000;
    localparam int MS_CYCLES     = CLK_HZ / 1000;
    localparam int RETRY_SHORT_MS = 500;
    localparam int RETRY_LONG_MS  = 5000;
    localparam int DETECT0_MS    = 300;
    localparam int DETECT1_MS    = 500;
    localparam int DETECT2_MS    = 1000;
    localparam int DETECT3_MS    = 5000;
    // Skew step is 0.2 us; code 1 is 0.4 us
    localparam int SKEW_STEP_NS  = 200;
    localparam int SKEW_STEP_CYC = (SKEW_STEP_NS * (CLK_HZ / 1_000_000))
                                   / 1000;

    // Hysteresis in mV
    localparam logic [7:0] HYST_LOW_MV  = 8'h05;
    localparam logic [7:0] HYST_HIGH_MV = 8'h32;

    // Irq status bits
    localparam int IRQ_STALL  = 0;
    localparam int IRQ_RETRY  = 1;
    localparam int IRQ_SPEED  = 2;

    typedef enum logic [1:0] {
        RESP_LATCH,
        RESP_RETRY,
        RESP_REPORT,
        RESP_IGNORE
    } stall_resp_t;

    typedef struct packed {
        logic [2:0] hall_state;
        logic       hall_valid_step;
    } hall_in_t;

    typedef struct packed {
        logic [5:0] gate;       // {hi_a,lo_a,hi_b,lo_b,hi_c,lo_c}
        logic       coasting;
        logic       braking;
    } phase_drive_t;

endpackage

// ===== rtl/trapezoid_motor_drive_config.sv
`timescale 1ns/1ps
// Functional notes
// - Hysteresis select 0 gives 5 mV and 1 gives 50 mV.
// - With brake active, stop-style 0 brakes actively and 1 coasts.
// - Coast bit 1 releases all phase drive; 0 leaves coast.
// - Brake bit 1 enters brake mode; 0 disables it.
// - Direction bit 0 is clockwise, 1 anti-clockwise, reset 1.
// - Speed pulse is commutation rate divided by 1,2,4,8, reset code 1.
// - Auto retry waits 500 ms for retry bit 0 and 5000 ms for 1.
// - Stall detect time is 300, 500, 1000 or 5000 ms for codes 0-3.
// - Response 0 latches the stall fault until cleared.
// - Response 1, the reset value, clears the fault after retry time.
// - Response 2 only reports and keeps driving.
// - Response 3 neither reports nor acts.
// - Phase lead is 0,4,7,11,15,20,25,30 degrees for codes 0-7.
// - Skew equalizing applies only while its enable bit is 1.
// - Skew goal is 0 us at code 0, else 0.2 us times (code+1).
module trapezoid_motor_drive_config #(
    parameter int MS_CYC = motor_cfg_pkg::MS_CYCLES
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [7:0]                  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Motor side
    input  wire motor_cfg_pkg::hall_in_t     hall,
    input  wire logic                        drive_request,
    input  wire logic                        brake_request,
    input  wire logic [5:0]                  drive_delay_in,
    output motor_cfg_pkg::phase_drive_t      drive,
    output logic      [7:0]                  hall_hyst_mv,
    output logic      [4:0]                  phase_lead_deg,
    output logic                             speed_pulse_output,
    output logic                             stall_fault,
    output logic                             irq
);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] spin_reg, speed_reg, lead_reg, skew_reg;
    logic [2:0] irq_status_reg, irq_mask_reg;
    logic       fault_reg, retry_reg;
    logic [31:0] detect_cnt_reg, retry_cnt_reg;
    logic [2:0] div_cnt_reg;
    logic       pulse_reg;
    logic [5:0] gate_reg;
    logic [4:0] skew_cnt_reg;
    logic       skew_busy_reg;
    logic [5:0] pending_reg;

    // ----------------------------------------
    // Field decode
    // ----------------------------------------
    wire logic       hyst_sel     = spin_reg[4];
    wire logic       stop_coast   = spin_reg[3];
    wire logic       coast_bit    = spin_reg[2];
    wire logic       brake_bit    = spin_reg[1];
    wire logic       dir_ccw      = spin_reg[0];
    wire logic [1:0] pulse_div    = speed_reg[7:6];
    wire logic       retry_long   = speed_reg[4];
    wire logic [1:0] detect_sel   = speed_reg[3:2];
    wire motor_cfg_pkg::stall_resp_t resp =
        motor_cfg_pkg::stall_resp_t'(speed_reg[1:0]);
    wire logic [2:0] lead_code    = lead_reg[2:0];
    wire logic       skew_on      = skew_reg[4];
    wire logic [3:0] skew_goal    = skew_reg[3:0];

    function automatic logic [31:0] ms_to_cyc(input int ms);
        ms_to_cyc = 32'(ms * MS_CYC);
    endfunction

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    wire logic       acc   = psel && penable;
    wire logic       wr    = acc && pwrite;
    wire logic [7:0] idx   = {2'b00, paddr[7:2]};
    wire logic       hit_spin  = idx == motor_cfg_pkg::SPIN_STOP_IDX;
    wire logic       hit_speed = idx == motor_cfg_pkg::SPEED_STALL_IDX;
    wire logic       hit_lead  = idx == motor_cfg_pkg::PHASE_LEAD_IDX;
    wire logic       hit_skew  = idx == motor_cfg_pkg::SKEW_IDX;
    wire logic       hit_ist   = idx == motor_cfg_pkg::IRQ_STATUS_IDX;
    wire logic       hit_imask = idx == motor_cfg_pkg::IRQ_MASK_IDX;
    wire logic       hit_state = idx == motor_cfg_pkg::STATE_IDX;
    wire logic       hit_fclr  = idx == motor_cfg_pkg::FAULT_CLR_IDX;
    wire logic       mapped = hit_spin | hit_speed | hit_lead | hit_skew
                              | hit_ist | hit_imask | hit_state | hit_fclr;

    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;

    wire logic [7:0] rd_mux =
        hit_spin  ? spin_reg :
        hit_speed ? speed_reg :
        hit_lead  ? lead_reg :
        hit_skew  ? skew_reg :
        hit_ist   ? {5'h00, irq_status_reg} :
        hit_imask ? {5'h00, irq_mask_reg} :
        hit_state ? {6'h00, retry_reg, fault_reg} : 8'h00;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata <= {24'h00_0000, rd_mux};
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            spin_reg  <= motor_cfg_pkg::SPIN_STOP_RST;
            speed_reg <= motor_cfg_pkg::SPEED_STALL_RST;
            lead_reg  <= motor_cfg_pkg::PHASE_LEAD_RST;
            skew_reg  <= motor_cfg_pkg::SKEW_RST;
            irq_mask_reg <= 3'h0;
        end
        else if (wr)
        begin
            if (hit_spin)
                spin_reg <= pwdata[7:0] & motor_cfg_pkg::SPIN_STOP_WMASK;
            if (hit_speed)
                speed_reg <= pwdata[7:0] & motor_cfg_pkg::SPEED_STALL_WMASK;
            if (hit_lead)
                lead_reg <= pwdata[7:0] & motor_cfg_pkg::PHASE_LEAD_WMASK;
            if (hit_skew)
                skew_reg <= pwdata[7:0] & motor_cfg_pkg::SKEW_WMASK;
            if (hit_imask)
                irq_mask_reg <= pwdata[2:0];
        end
    end

    // ----------------------------------------
    // Hysteresis and phase lead
    // ----------------------------------------
    // hysteresis level select
    assign hall_hyst_mv = hyst_sel ? motor_cfg_pkg::HYST_HIGH_MV
                                   : motor_cfg_pkg::HYST_LOW_MV;

    always_comb
    begin
        unique case (lead_code)
            3'h0: phase_lead_deg = 5'd0;
            3'h1: phase_lead_deg = 5'd4;
            3'h2: phase_lead_deg = 5'd7;
            3'h3: phase_lead_deg = 5'd11;
            3'h4: phase_lead_deg = 5'd15;
            3'h5: phase_lead_deg = 5'd20;
            3'h6: phase_lead_deg = 5'd25;
            3'h7: phase_lead_deg = 5'd30;
        endcase
    end

    // ----------------------------------------
    // Stall detection and response
    // ----------------------------------------
    // detect time select
    wire logic [31:0] detect_lim =
        detect_sel == 2'h0 ? ms_to_cyc(motor_cfg_pkg::DETECT0_MS) :
        detect_sel == 2'h1 ? ms_to_cyc(motor_cfg_pkg::DETECT1_MS) :
        detect_sel == 2'h2 ? ms_to_cyc(motor_cfg_pkg::DETECT2_MS) :
                             ms_to_cyc(motor_cfg_pkg::DETECT3_MS);
    wire logic [31:0] retry_lim = retry_long
        ? ms_to_cyc(motor_cfg_pkg::RETRY_LONG_MS)
        : ms_to_cyc(motor_cfg_pkg::RETRY_SHORT_MS);

    wire logic driven  = drive_request && !coast_bit && !brake_bit
                         && !brake_request && !fault_reg;
    // no valid Hall step over the whole window
    wire logic stall_hit = driven && !hall.hall_valid_step
                           && detect_cnt_reg == detect_lim - 32'd1;
    wire logic retry_done = retry_reg && retry_cnt_reg == retry_lim - 32'd1;
    wire logic fault_clr  = wr && hit_fclr && pwdata[0];
    wire logic acts       = resp == motor_cfg_pkg::RESP_LATCH
                            || resp == motor_cfg_pkg::RESP_RETRY;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            detect_cnt_reg <= 32'h0000_0000;
        else if (!driven || hall.hall_valid_step || stall_hit)
            detect_cnt_reg <= 32'h0000_0000;
        else
            detect_cnt_reg <= detect_cnt_reg + 32'd1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fault_reg     <= 1'b0;
            retry_reg     <= 1'b0;
            retry_cnt_reg <= 32'h0000_0000;
        end
        else if (stall_hit && acts)
        begin
            fault_reg     <= 1'b1;
            retry_reg     <= resp == motor_cfg_pkg::RESP_RETRY;
            retry_cnt_reg <= 32'h0000_0000;
        end
        else if (retry_done)
        begin
            fault_reg <= 1'b0;
            retry_reg <= 1'b0;
        end
        else if (fault_clr && !retry_reg)
            fault_reg <= 1'b0;
        else if (retry_reg)
            retry_cnt_reg <= retry_cnt_reg + 32'd1;
    end

    assign stall_fault = fault_reg;

    // ----------------------------------------
    // Speed pulse divider
    // ----------------------------------------
    // divide by 1,2,4,8
    wire logic [2:0] div_top = 3'((4'd1 << pulse_div) - 4'd1);
    wire logic       div_wrap = div_cnt_reg >= div_top;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            div_cnt_reg <= 3'h0;
            pulse_reg   <= 1'b0;
        end
        else if (hall.hall_valid_step)
        begin
            div_cnt_reg <= div_wrap ? 3'h0 : div_cnt_reg + 3'd1;
            if (div_wrap)
                pulse_reg <= !pulse_reg;
        end
    end

    assign speed_pulse_output = pulse_reg;

    // ----------------------------------------
    // Commutation
    // ----------------------------------------
    // direction swaps high and low phase choice
    function automatic logic [5:0] commutate(input logic [2:0] h,
                                             input logic ccw);
        logic [5:0] g;
        g = 6'h00;
        unique case (h)
            3'h1: g = ccw ? 6'b01_10_00 : 6'b10_01_00;
            3'h2: g = ccw ? 6'b10_00_01 : 6'b01_00_10;
            3'h3: g = ccw ? 6'b00_10_01 : 6'b00_01_10;
            3'h4: g = ccw ? 6'b00_01_10 : 6'b00_10_01;
            3'h5: g = ccw ? 6'b01_00_10 : 6'b10_00_01;
            3'h6: g = ccw ? 6'b10_01_00 : 6'b01_10_00;
            default: g = 6'h00;
        endcase
        commutate = g;
    endfunction

    wire logic brake_now = brake_bit || brake_request;
    // stop style picks brake or coast
    wire logic do_coast = coast_bit || (brake_now && stop_coast)
                          || fault_reg;
    wire logic do_brake = brake_now && !stop_coast && !coast_bit;
    // coast releases, brake shorts all low sides
    wire logic [5:0] gate_next =
        do_coast ? 6'h00 :
        do_brake ? 6'b01_01_01 :
        drive_request ? commutate(hall.hall_state, dir_ccw) : 6'h00;

    // goal in 0.2 us steps: code 0 is 0, else code+1
    wire logic [4:0] goal_steps = skew_goal == 4'h0 ? 5'd0
                                  : {1'b0, skew_goal} + 5'd1;
    wire logic [5:0] goal_cyc = 6'(goal_steps * 5'(motor_cfg_pkg::
                                SKEW_STEP_CYC));
    // variable part tops up intrinsic delay to the goal
    wire logic [5:0] var_cyc = goal_cyc > drive_delay_in
                               ? goal_cyc - drive_delay_in : 6'd0;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            gate_reg      <= 6'h00;
            pending_reg   <= 6'h00;
            skew_cnt_reg  <= 5'h00;
            skew_busy_reg <= 1'b0;
        end
        else if ((!skew_on || var_cyc == 6'd0) && !skew_busy_reg)
            gate_reg <= gate_next;
        else if (!skew_busy_reg && gate_next != gate_reg)
        begin
            pending_reg   <= gate_next;
            skew_cnt_reg  <= 5'(var_cyc - 6'd1);
            skew_busy_reg <= 1'b1;
        end
        else if (skew_busy_reg && skew_cnt_reg == 5'h00)
        begin
            gate_reg      <= pending_reg;
            skew_busy_reg <= 1'b0;
        end
        else if (skew_busy_reg)
            skew_cnt_reg <= skew_cnt_reg - 5'd1;
    end

    assign drive.gate     = gate_reg;
    assign drive.coasting = do_coast;
    assign drive.braking  = do_brake;

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    // ignore only: stall not reported
    wire logic report = stall_hit
                        && resp != motor_cfg_pkg::RESP_IGNORE;
    wire logic [2:0] ev = {hall.hall_valid_step && div_wrap,
                           retry_done, report};
    wire logic [2:0] wclr = (wr && hit_ist) ? pwdata[2:0] : 3'h0;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            irq_status_reg <= 3'h0;
        else
            irq_status_reg <= ev | (irq_status_reg & ~wclr);
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence stall_seq;
        stall_hit && resp == motor_cfg_pkg::RESP_RETRY;
    endsequence

    stall_latch_a: assert property (
        @(posedge clk) disable iff (rst)
        stall_hit && resp == motor_cfg_pkg::RESP_LATCH
        |=> fault_reg && !retry_reg)
        else $error("latched stall fault not set");

    retry_arm_a: assert property (
        @(posedge clk) disable iff (rst)
        stall_seq |=> fault_reg && retry_reg)
        else $error("retrying fault not armed");

    retry_end_a: assert property (
        @(posedge clk) disable iff (rst)
        retry_done |=> !fault_reg)
        else $error("fault stayed after retry time");

    report_only_a: assert property (
        @(posedge clk) disable iff (rst)
        stall_hit && resp == motor_cfg_pkg::RESP_REPORT
        |=> !fault_reg && irq_status_reg[motor_cfg_pkg::IRQ_STALL])
        else $error("report-only stall misbehaved");

    ignore_stall_a: assert property (
        @(posedge clk) disable iff (rst)
        stall_hit && resp == motor_cfg_pkg::RESP_IGNORE
        && !irq_status_reg[0] |=> !fault_reg && !irq_status_reg[0])
        else $error("ignored stall was acted on");

    coast_out_a: assert property (
        @(posedge clk) disable iff (rst)
        coast_bit && !skew_on |=> gate_reg == 6'h00)
        else $error("phases driven while coasting");

    brake_out_a: assert property (
        @(posedge clk) disable iff (rst)
        brake_bit && !stop_coast && !coast_bit && !skew_on
        && !fault_reg |=> gate_reg == 6'b01_01_01)
        else $error("brake did not short low sides");

    hyst_sel_a: assert property (
        @(posedge clk) disable iff (rst)
        hall_hyst_mv == (spin_reg[4] ? 8'h32 : 8'h05))
        else $error("wrong hysteresis level");

    detect_bound_a: assert property (
        @(posedge clk) disable iff (rst)
        detect_cnt_reg < detect_lim)
        else $error("detect counter ran past window");

endmodule

// ===== sim/hall_motor_model.sv
`timescale 1ns/1ps
module hall_motor_model #(
    parameter int STEP_CYC = 20
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst,
    // Drive from the block, bench command
    input  wire motor_cfg_pkg::phase_drive_t drive,
    input  wire logic                        spin,
    // Hall position
    output motor_cfg_pkg::hall_in_t          hall
);
    // ----------------------------------------
    // Rotor position
    // ----------------------------------------
    // Gray order: one sensor flips per step
    localparam logic [2:0] SEQ [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
    logic [7:0] cnt_reg;
    logic [2:0] pos_reg;
    logic       step_reg;
    // A braked rotor stops dead
    wire        turning = spin & ~drive.braking;
    wire        wrap    = turning && cnt_reg == 8'(STEP_CYC - 1);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_reg  <= 8'h00;
            pos_reg  <= 3'h0;
            step_reg <= 1'h0;
        end
        else
        begin
            step_reg <= wrap;
            cnt_reg  <= (wrap || !turning) ? 8'h00 : cnt_reg + 8'h01;
            if (wrap)
                pos_reg <= (pos_reg == 3'h5) ? 3'h0 : pos_reg + 3'h1;
        end
    end

    assign hall.hall_state      = SEQ[pos_reg];
    assign hall.hall_valid_step = step_reg;
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic                        clk;
    logic                        rst;
    logic                        psel;
    logic                        penable;
    logic                        pwrite;
    logic [7:0]                  paddr;
    logic [31:0]                 pwdata;
    logic [31:0]                 prdata;
    logic                        pready;
    logic                        pslverr;
    motor_cfg_pkg::hall_in_t     hall;
    motor_cfg_pkg::phase_drive_t drive;
    logic                        drive_request;
    logic                        brake_request;
    logic [5:0]                  drive_delay_in;
    logic [7:0]                  hall_hyst_mv;
    logic [4:0]                  phase_lead_deg;
    logic                        speed_pulse_output;
    logic                        stall_fault;
    logic                        irq;
    logic                        spin;
    int                          errors;
    int                          n_compared;
    localparam logic [7:0] ST = motor_cfg_pkg::IRQ_STATUS_IDX;
    localparam logic [7:0] MK = motor_cfg_pkg::IRQ_MASK_IDX;

    // Two ms-cycles keep stall times short
    trapezoid_motor_drive_config #(.MS_CYC(2)) DUT (.clk(clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hall(hall), .drive_request(drive_request),
        .brake_request(brake_request), .drive_delay_in(drive_delay_in),
        .drive(drive), .hall_hyst_mv(hall_hyst_mv),
        .phase_lead_deg(phase_lead_deg),
        .speed_pulse_output(speed_pulse_output),
        .stall_fault(stall_fault), .irq(irq));
    hall_motor_model motor (.clk(clk), .rst(rst), .drive(drive),
        .spin(spin), .hall(hall));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic complete_run;
        if (errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            errors++;
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] idx,
        input logic [7:0] wd, output logic [7:0] rd, output logic err);
        @(posedge clk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= {idx[5:0], 2'h0};
        pwdata  <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1)
            @(posedge clk);
        rd = prdata[7:0];
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        // Let the write land before callers look
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] r;
        logic       e;
        apb(1'h1, idx, d, r, e);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [7:0] m,
        input logic [7:0] exp);
        logic [7:0] r;
        logic       e;
        apb(1'h0, idx, 8'h00, r, e);
        chk(r & m, exp);
    endtask

    task automatic flags(input logic [1:0] e);
        repeat (2) @(posedge clk);
        chk(drive[1:0], e);
    endtask

    task automatic stop_motor;
        @(posedge clk iff hall.hall_valid_step);
        spin <= 1'h0;
    endtask

    task automatic wait_lvl(input logic lv, input int lo, input int hi);
        int n;
        n = 0;
        while (stall_fault !== lv && n <= hi)
        begin
            @(posedge clk);
            n++;
        end
        chk(n >= lo && n <= hi, 1'h1);
    endtask

    task automatic lat(output int n);
        logic [5:0] g;
        @(posedge clk iff hall.hall_valid_step);
        g = drive.gate;
        n = 0;
        while (drive.gate === g && n < 19)
        begin
            @(posedge clk);
            n++;
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        logic [7:0] ix [4] = '{8'h09, 8'h0A, 8'h0B, 8'h0C};
        logic [7:0] rv [4] = '{8'h01, 8'h41, 8'h00, 8'h00};
        logic [7:0] wm [4] = '{8'h1F, 8'hDF, 8'h07, 8'h1F};
        logic [7:0] r;
        logic       e;
        chk(hall_hyst_mv, 8'h05);
        for (int i = 0; i < 4; i++)
        begin
            rdc(ix[i], 8'hFF, rv[i]);
            wr(ix[i], 8'hFF);
            rdc(ix[i], 8'hFF, wm[i]);
            wr(ix[i], rv[i]);
        end
        apb(1'h0, 8'h20, 8'h00, r, e);
        chk(e, 1'h1);
        chk(r, 8'h00);
        wr(8'h09, 8'h11);
        chk(hall_hyst_mv, 8'h32);
        wr(8'h09, 8'h01);
        chk(hall_hyst_mv, 8'h05);
    endtask

    task automatic t_lead;
        logic [4:0] deg [8] = '{5'h00, 5'h04, 5'h07, 5'h0B, 5'h0F, 5'h14,
                                5'h19, 5'h1E};
        for (int i = 0; i < 8; i++)
        begin
            wr(8'h0B, 8'(i));
            chk(phase_lead_deg, deg[i]);
        end
    endtask

    task automatic t_stop;
        wr(8'h09, 8'h05);
        flags(2'h2);
        chk(drive.gate, 6'h00);
        wr(8'h09, 8'h03);
        flags(2'h1);
        wr(8'h09, 8'h0B);
        flags(2'h2);
        wr(8'h09, 8'h01);
        brake_request <= 1'h1;
        flags(2'h1);
        wr(8'h09, 8'h09);
        flags(2'h2);
        brake_request <= 1'h0;
        wr(8'h09, 8'h01);
        flags(2'h0);
    endtask

    task automatic t_dir;
        logic [5:0] g;
        drive_request <= 1'h1;
        wr(8'h09, 8'h00);
        repeat (3) @(posedge clk);
        g = drive.gate;
        wr(8'h09, 8'h01);
        repeat (3) @(posedge clk);
        chk(drive.gate !== g, 1'h1);
        spin <= 1'h1;
    endtask

    task automatic t_speed;
        int         t;
        logic       p;
        for (int c = 0; c < 4; c++)
        begin
            wr(8'h0A, {2'(c), 6'h01});
            @(posedge clk iff hall.hall_valid_step);
            repeat (3) @(posedge clk);
            t = 0;
            p = speed_pulse_output;
            repeat (480)
            begin
                @(posedge clk);
                t += int'(speed_pulse_output !== p);
                p = speed_pulse_output;
            end
            chk(t, 24 >> c);
        end
    endtask

    task automatic t_skew;
        int a;
        int b;
        drive_delay_in <= 6'h02;
        wr(8'h0A, 8'h43);
        wr(8'h0C, 8'h04);
        lat(a);
        wr(8'h0C, 8'h14);
        lat(b);
        chk(b - a, 8);
        wr(8'h0C, 8'h11);
        lat(b);
        chk(b - a, 2);
        wr(8'h0C, 8'h04);
        lat(b);
        chk(b - a, 0);
    endtask

    task automatic t_retry(input logic rb);
        wr(8'h0A, rb ? 8'h51 : 8'h41);
        stop_motor();
        wait_lvl(1'h1, 595, 606);
        wait_lvl(1'h0, rb ? 9995 : 995, rb ? 10006 : 1006);
        wr(MK, 8'h06);
        chk(irq, 1'h1);
        wr(MK, 8'h00);
        chk(irq, 1'h0);
        wr(ST, 8'h07);
        rdc(ST, 8'h01, 8'h00);
        spin <= 1'h1;
    endtask

    task automatic t_latch;
        wr(8'h0A, 8'h40);
        stop_motor();
        wait_lvl(1'h1, 595, 606);
        repeat (2000) @(posedge clk);
        chk(stall_fault, 1'h1);
        chk(drive[1:0], 2'h2);
        wr(motor_cfg_pkg::FAULT_CLR_IDX, 8'h01);
        chk(stall_fault, 1'h0);
        spin <= 1'h1;
    endtask

    task automatic t_report;
        wr(8'h0A, 8'h46);
        wr(ST, 8'h07);
        stop_motor();
        repeat (985) @(posedge clk);
        rdc(ST, 8'h01, 8'h00);
        repeat (15) @(posedge clk);
        rdc(ST, 8'h01, 8'h01);
        chk(stall_fault, 1'h0);
        chk(drive.gate !== 6'h00, 1'h1);
        wr(8'h0A, 8'h43);
        wr(ST, 8'h07);
        repeat (800) @(posedge clk);
        chk(stall_fault, 1'h0);
        rdc(ST, 8'h01, 8'h00);
        spin <= 1'h1;
    endtask

    initial
    begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    initial
    begin
        #8_000_000;
        errors++;
        complete_run();
    end

    initial
    begin
        errors = 0;
        n_compared = 0;
        rst = 1'h1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {drive_request, brake_request, spin} = 3'h0;
        drive_delay_in = 6'h00;
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        t_regs();
        t_lead();
        t_stop();
        t_dir();
        t_speed();
        t_skew();
        t_retry(1'h0);
        t_retry(1'h1);
        t_latch();
        t_report();
        complete_run();
    end
endmodule
